//--- logic/ieg_cfg.svh
// Offsets, field positions, reset values and class masks of the interrupt gating block
`ifndef IEG_CFG_SVH
`define IEG_CFG_SVH

`define IEG_ADDR_W        12
`define IEG_OFS_ENABLE    12'h000
`define IEG_OFS_PENDING   12'h004
`define IEG_OFS_MASK      12'h008

`define IEG_B_RAM_INIT    0
`define IEG_B_EEPROM      1
`define IEG_B_PARITY      2
`define IEG_B_TT_ROLL     3
`define IEG_B_ILL_CMD     8
`define IEG_B_MSG_ERR     10
`define IEG_B_BCAST       11
`define IEG_B_WORD_ADDR   12
`define IEG_B_IDX_ZERO    13

`define IEG_ENABLE_RST    16'h0007
`define IEG_ENABLE_FIXED  16'h0007
`define IEG_ENABLE_WMASK  16'h3d08
`define IEG_PENDING_RST   16'h0000
`define IEG_MASK_RST      16'h0000
`define IEG_HW_CLASS      16'h000f
`define IEG_MSG_CLASS     16'h3d00

`define IEG_TT_MAX        16'hffff
`define IEG_TT_ZERO       16'h0000

`endif

//--- logic/ieg_pkg.sv
// Types shared by the interrupt gating block
package ieg_pkg;

   typedef logic [15:0] ieg_word_t;

   typedef struct packed {
      logic addr_parity_fail_int;
      logic eeprom_checksum_fail_int;
      logic ram_init_fail_int;
      logic illegal_command_int;
      logic message_error_int;
      logic index_equal_zero_int;
      logic word_addr_match_int;
      logic broadcast_rx_int;
   } ieg_evt_s;

   typedef struct packed {
      logic index_equal_zero_int;
      logic word_addr_match_int;
      logic broadcast_rx_int;
   } ieg_desc_s;

   typedef enum logic [0:0] {
      IEG_IDLE,
      IEG_ANSWER
   } ieg_apb_e;

endpackage

//--- logic/ieg_top.sv
// Interrupt enable, pending and output gating with APB register access
//
// Local design decisions: the register offsets and the APB register port.
`timescale 1ns/100ps
`include "ieg_cfg.svh"

// Summary of operation
// (RULE1) Enabled time-tag wrap from all ones to zero sets pending and hardware output.
// (RULE2) Enabled address parity error drives the hardware interrupt output.
// (RULE3) Parity, checksum and RAM-init enables read one and ignore host clears.
// (RULE4) Enabled EEPROM checksum failure drives the hardware interrupt output.
// (RULE5) Enabled RAM init mismatch drives the hardware interrupt output.
// (RULE6) A cleared enable blocks the hardware and message outputs and leaves that pending bit untouched.
// (RULE7) Events seen while disabled are dropped, never signalled later.
// (RULE8) Index, word-address and broadcast events need descriptor bit and global enable.
// (RULE9) Illegal command, message error and hardware events ignore descriptor bits.
// (RULE10) An event passing its enables sets pending and raises its output.
// (RULE11) Enabled illegal commands drive the message output, not the hardware one.
// (RULE12) Hardware and message outputs are clocked and stay high while an enabled pending bit of their class remains.
module ieg_top (
   input  wire logic                      i_ref_clk,
   input  wire logic                      i_arst_n,
   input  wire logic                      i_psel,
   input  wire logic                      i_penable,
   input  wire logic                      i_pwrite,
   input  wire logic [`IEG_ADDR_W-1:0]    i_paddr,
   input  wire logic [31:0]               i_pwdata,
   input  wire logic [15:0]               i_timetag,
   input  wire ieg_pkg::ieg_evt_s         i_evt,
   input  wire ieg_pkg::ieg_desc_s        i_desc,
   output logic                           o_pready,
   output logic [31:0]                    o_prdata,
   output logic                           o_pslverr,
   output logic                           o_hardware_irq_out,
   output logic                           o_message_irq_out,
   output logic                           o_irq
);

   logic [1:0]          rst_pipe;
   logic                rst_n;

   ieg_pkg::ieg_apb_e   state;
   ieg_pkg::ieg_apb_e   next_state;
   logic                next_pready;
   logic [31:0]         next_prdata;
   logic                next_pslverr;

   ieg_pkg::ieg_word_t  enable;
   ieg_pkg::ieg_word_t  pending;
   ieg_pkg::ieg_word_t  mask;
   logic [15:0]         tt_prev;
   ieg_pkg::ieg_word_t  next_enable;
   ieg_pkg::ieg_word_t  next_pending;
   ieg_pkg::ieg_word_t  next_mask;
   logic [15:0]         next_tt_prev;
   logic                next_hw_out;
   logic                next_msg_out;
   logic                next_irq;

   logic                wr_commit;
   logic                tt_wrap;
   ieg_pkg::ieg_word_t  raw_evt;
   ieg_pkg::ieg_word_t  set_vec;
   ieg_pkg::ieg_word_t  w1c;

   function automatic logic addr_is(input logic [`IEG_ADDR_W-1:0] addr,
                                    input logic [`IEG_ADDR_W-1:0] ofs);
      addr_is = (addr[`IEG_ADDR_W-1:2] == ofs[`IEG_ADDR_W-1:2]);
   endfunction

   function automatic logic class_any(input ieg_pkg::ieg_word_t pend,
                                      input ieg_pkg::ieg_word_t en,
                                      input ieg_pkg::ieg_word_t cls);
      class_any = |(pend & en & cls);
   endfunction

   // Reset released through two flops, asserted at once
   always_ff @(posedge i_ref_clk or negedge i_arst_n) begin
      if (!i_arst_n) begin
         rst_pipe <= 2'h0;
      end else begin
         rst_pipe <= {rst_pipe[0], 1'b1};
      end
   end

   assign rst_n = rst_pipe[1];

   // APB slave: one wait state, so read data and pready both come from flops
   always_comb begin
      next_state   = state;
      next_pready  = 1'b0;
      next_prdata  = 32'h0000_0000;
      next_pslverr = 1'b0;
      case (state)
         ieg_pkg::IEG_IDLE: begin
            if (i_psel && i_penable) begin
               next_state  = ieg_pkg::IEG_ANSWER;
               next_pready = 1'b1;
               if (addr_is(i_paddr, `IEG_OFS_ENABLE)) begin
                  next_prdata = {16'h0000, enable};
               end else if (addr_is(i_paddr, `IEG_OFS_PENDING)) begin
                  next_prdata = {16'h0000, pending};
               end else if (addr_is(i_paddr, `IEG_OFS_MASK)) begin
                  next_prdata = {16'h0000, mask};
               end else begin
                  next_pslverr = 1'b1;
               end
            end
         end
         ieg_pkg::IEG_ANSWER: begin
            next_state = ieg_pkg::IEG_IDLE;
         end
         default: begin
            next_state = ieg_pkg::IEG_IDLE;
         end
      endcase
   end

   always_ff @(posedge i_ref_clk or negedge rst_n) begin
      if (!rst_n) begin
         state     <= ieg_pkg::IEG_IDLE;
         o_pready  <= 1'b0;
         o_prdata  <= 32'h0000_0000;
         o_pslverr <= 1'b0;
      end else begin
         state     <= next_state;
         o_pready  <= next_pready;
         o_prdata  <= next_prdata;
         o_pslverr <= next_pslverr;
      end
   end

   // Writes land only on the edge where the master sees pready
   assign wr_commit = (state == ieg_pkg::IEG_ANSWER) && i_psel && i_penable && i_pwrite;

   // Enable, pending and mask registers plus output gating
   always_comb begin
      next_enable  = enable;
      next_mask    = mask;
      w1c          = 16'h0000;
      next_tt_prev = i_timetag;
      tt_wrap      = (tt_prev == `IEG_TT_MAX) && (i_timetag == `IEG_TT_ZERO); // RULE1
      if (wr_commit && addr_is(i_paddr, `IEG_OFS_ENABLE)) begin
         // Failure enables are forced high so a host write cannot clear them
         next_enable = (i_pwdata[15:0] & `IEG_ENABLE_WMASK) | `IEG_ENABLE_FIXED; // RULE3
      end else if (wr_commit && addr_is(i_paddr, `IEG_OFS_PENDING)) begin
         w1c = i_pwdata[15:0];
      end else if (wr_commit && addr_is(i_paddr, `IEG_OFS_MASK)) begin
         next_mask = i_pwdata[15:0];
      end
      raw_evt = 16'h0000;
      raw_evt[`IEG_B_TT_ROLL]  = tt_wrap; // RULE1
      raw_evt[`IEG_B_PARITY]   = i_evt.addr_parity_fail_int; // RULE2
      raw_evt[`IEG_B_EEPROM]   = i_evt.eeprom_checksum_fail_int; // RULE4
      raw_evt[`IEG_B_RAM_INIT] = i_evt.ram_init_fail_int; // RULE5
      raw_evt[`IEG_B_ILL_CMD]  = i_evt.illegal_command_int; // RULE9
      raw_evt[`IEG_B_MSG_ERR]  = i_evt.message_error_int; // RULE9
      raw_evt[`IEG_B_IDX_ZERO] = i_evt.index_equal_zero_int & i_desc.index_equal_zero_int; // RULE8
      raw_evt[`IEG_B_WORD_ADDR] = i_evt.word_addr_match_int & i_desc.word_addr_match_int; // RULE8
      raw_evt[`IEG_B_BCAST]    = i_evt.broadcast_rx_int & i_desc.broadcast_rx_int; // RULE8
      // Gated events are dropped here, nothing is held for a later enable
      set_vec = raw_evt & enable; // RULE6 RULE7
      // Set wins over a same-cycle write-one-to-clear
      next_pending = (pending & ~w1c) | set_vec; // RULE10
      next_hw_out  = class_any(next_pending, next_enable, `IEG_HW_CLASS); // RULE12
      next_msg_out = class_any(next_pending, next_enable, `IEG_MSG_CLASS); // RULE11 RULE12
      next_irq     = |(next_pending & ~next_mask);
   end

   always_ff @(posedge i_ref_clk or negedge rst_n) begin
      if (!rst_n) begin
         enable             <= `IEG_ENABLE_RST;
         pending            <= `IEG_PENDING_RST;
         mask               <= `IEG_MASK_RST;
         tt_prev            <= `IEG_TT_ZERO;
         o_hardware_irq_out <= 1'b0;
         o_message_irq_out  <= 1'b0;
         o_irq              <= 1'b0;
      end else begin
         enable             <= next_enable;
         pending            <= next_pending;
         mask               <= next_mask;
         tt_prev            <= next_tt_prev;
         o_hardware_irq_out <= next_hw_out;
         o_message_irq_out  <= next_msg_out;
         o_irq              <= next_irq;
      end
   end

   default clocking cb @(posedge i_ref_clk);
   endclocking

   default disable iff (!rst_n);

   sequence s_tt_wrap_on;
      tt_wrap && enable[`IEG_B_TT_ROLL];
   endsequence

   sequence s_tt_wrap_missed;
      (tt_wrap && !enable[`IEG_B_TT_ROLL] && !pending[`IEG_B_TT_ROLL]) ##1 (!tt_wrap) [*2];
   endsequence

   sequence s_idx_no_desc;
      i_evt.index_equal_zero_int && !i_desc.index_equal_zero_int
         && !pending[`IEG_B_IDX_ZERO];
   endsequence

   sequence s_apb_access;
      i_psel && i_penable && !o_pready && (state == ieg_pkg::IEG_IDLE);
   endsequence

   a_tt_wrap_sets: assert property ( // RULE1
      s_tt_wrap_on |=> pending[`IEG_B_TT_ROLL] && o_hardware_irq_out)
      else $error("Time-tag wrap did not set pending and hardware output");

   a_parity_hw_out: assert property ( // RULE2
      i_evt.addr_parity_fail_int |=> pending[`IEG_B_PARITY] && o_hardware_irq_out)
      else $error("Address parity error did not raise hardware output");

   a_fixed_enables_high: assert property ( // RULE3
      enable[2:0] == 3'h7)
      else $error("Failure enable bits are not all high");

   a_eeprom_hw_out: assert property ( // RULE4
      i_evt.eeprom_checksum_fail_int |=> pending[`IEG_B_EEPROM] && o_hardware_irq_out)
      else $error("Checksum failure did not raise hardware output");

   a_ram_init_hw_out: assert property ( // RULE5
      i_evt.ram_init_fail_int |=> pending[`IEG_B_RAM_INIT] && o_hardware_irq_out)
      else $error("RAM init failure did not raise hardware output");

   a_disabled_no_set: assert property ( // RULE6
      (!enable[`IEG_B_MSG_ERR] && !pending[`IEG_B_MSG_ERR]) |=> !pending[`IEG_B_MSG_ERR])
      else $error("Pending bit set while its enable was clear");

   // Re-enabling a bit that was latched while enabled may raise the output again
   a_disabled_out_low: assert property ( // RULE6
      (o_message_irq_out && !$past(o_message_irq_out))
      |-> ((($past(set_vec) & `IEG_MSG_CLASS) != 16'h0000)
         || (($past(pending) & ~$past(enable) & `IEG_MSG_CLASS) != 16'h0000)))
      else $error("Message output rose without an enabled event");

   a_tt_disabled_no_set: assert property ( // RULE6
      (!enable[`IEG_B_TT_ROLL] && !pending[`IEG_B_TT_ROLL]) |=> !pending[`IEG_B_TT_ROLL])
      else $error("Time-tag pending bit set while its enable was clear");

   a_no_late_signal: assert property ( // RULE7
      s_tt_wrap_missed |-> !pending[`IEG_B_TT_ROLL])
      else $error("Disabled time-tag wrap was signalled later");

   a_desc_gates_idx: assert property ( // RULE8
      s_idx_no_desc |=> !pending[`IEG_B_IDX_ZERO])
      else $error("Index event set pending without descriptor bit");

   a_desc_gates_word: assert property ( // RULE8
      (i_evt.word_addr_match_int && !i_desc.word_addr_match_int
         && !pending[`IEG_B_WORD_ADDR]) |=> !pending[`IEG_B_WORD_ADDR])
      else $error("Word-address event set pending without descriptor bit");

   a_desc_gates_bcast: assert property ( // RULE8
      (i_evt.broadcast_rx_int && !i_desc.broadcast_rx_int
         && !pending[`IEG_B_BCAST]) |=> !pending[`IEG_B_BCAST])
      else $error("Broadcast event set pending without descriptor bit");

   a_global_gates_idx: assert property ( // RULE8
      (i_evt.index_equal_zero_int && i_desc.index_equal_zero_int
         && !enable[`IEG_B_IDX_ZERO] && !pending[`IEG_B_IDX_ZERO])
      |=> !pending[`IEG_B_IDX_ZERO])
      else $error("Index event set pending without its global enable");

   a_ill_desc_ignored: assert property ( // RULE9
      (i_evt.illegal_command_int && enable[`IEG_B_ILL_CMD]) |=> pending[`IEG_B_ILL_CMD])
      else $error("Illegal command was not latched as pending");

   a_desc_ignored: assert property ( // RULE9
      (i_evt.message_error_int && enable[`IEG_B_MSG_ERR] && !i_desc.index_equal_zero_int)
      |=> pending[`IEG_B_MSG_ERR] && o_message_irq_out)
      else $error("Message error was gated by descriptor bits");

   a_pass_sets_both: assert property ( // RULE10
      (i_evt.word_addr_match_int && i_desc.word_addr_match_int && enable[`IEG_B_WORD_ADDR])
      |=> pending[`IEG_B_WORD_ADDR] && o_message_irq_out)
      else $error("Passing event did not set pending and output");

   a_illegal_msg_out: assert property ( // RULE11
      // A hardware event in the same cycle may raise the hardware output legally
      (i_evt.illegal_command_int && enable[`IEG_B_ILL_CMD]
         && ((((pending & enable) | set_vec) & `IEG_HW_CLASS) == 16'h0000))
      |=> o_message_irq_out && !o_hardware_irq_out)
      else $error("Illegal command drove the wrong output");

   a_out_level_hold: assert property ( // RULE12
      o_hardware_irq_out == class_any(pending, enable, `IEG_HW_CLASS))
      else $error("Hardware output disagrees with enabled pending bits");

   a_msg_level_hold: assert property ( // RULE12
      o_message_irq_out == class_any(pending, enable, `IEG_MSG_CLASS))
      else $error("Message output disagrees with enabled pending bits");

   a_irq_masked: assert property (
      (o_irq == |(pending & ~mask)))
      else $error("Interrupt line disagrees with unmasked pending bits");

   a_apb_one_wait: assert property (
      s_apb_access |=> o_pready ##1 !o_pready)
      else $error("APB answer not given after exactly one wait cycle");

   a_apb_refused: assert property (
      (i_psel && i_penable && (state == ieg_pkg::IEG_IDLE) && !addr_is(i_paddr, `IEG_OFS_ENABLE)
         && !addr_is(i_paddr, `IEG_OFS_PENDING) && !addr_is(i_paddr, `IEG_OFS_MASK))
      |=> o_pslverr && (o_prdata == 32'h0000_0000))
      else $error("Unmapped access was not refused");

endmodule

//--- verification/ieg_host_model.sv
// Host side: APB master that drives transfers and samples pready, read data and pslverr
`timescale 1ns/100ps
module ieg_host_model (
   input  wire logic        i_ref_clk,
   input  wire logic        i_pready,
   input  wire logic [31:0] i_prdata,
   input  wire logic        i_pslverr,
   output logic             o_psel,
   output logic             o_penable,
   output logic             o_pwrite,
   output logic [11:0]      o_paddr,
   output logic [31:0]      o_pwdata
);
   logic tmo;
   initial begin
      o_psel = 1'b0;
      o_penable = 1'b0;
      o_pwrite = 1'b0;
      o_paddr = 12'h000;
      o_pwdata = 32'h00000000;
      tmo = 1'b0;
   end
   // Called just after a rising edge; holds the request until pready is sampled
   task automatic xfer(input bit wr, input logic [11:0] a, input logic [31:0] d,
                       output logic [31:0] rd, output logic err);
      int n;
      n = 0;
      o_psel <= 1'b1;
      o_pwrite <= wr;
      o_paddr <= a;
      o_pwdata <= d;
      @(posedge i_ref_clk);
      o_penable <= 1'b1;
      do begin
         @(posedge i_ref_clk);
         n++;
      end while (i_pready !== 1'b1 && n < 20);
      rd = i_prdata;
      err = i_pslverr;
      if (i_pready !== 1'b1) tmo = 1'b1;
      o_psel <= 1'b0;
      o_penable <= 1'b0;
   endtask
endmodule

//--- verification/ieg_top_tb_top.sv
// Self-checking bench for the interrupt gating block
`timescale 1ns/100ps
`include "ieg_cfg.svh"
module ieg_top_tb_top;
   logic               clk = 1'b0;
   logic               arst_n = 1'b0;
   logic               psel, penable, pwrite, pready, pslverr, hw, msg, irq;
   logic [11:0]        paddr;
   logic [31:0]        pwdata, prdata, rd;
   logic               err;
   logic [15:0]        tt = 16'h0001;
   ieg_pkg::ieg_evt_s  evt = '0;
   ieg_pkg::ieg_desc_s desc = '0;
   int                 error_cnt = 0;
   int                 cmp_count = 0;
   int                 en = 7, pend = 0, msk = 0, set, w;
   logic [7:0]         ev;
   logic [2:0]         ds;
   bit                 wrap;

   always #25 clk = ~clk;

   ieg_top i_ieg_top (.i_ref_clk(clk), .i_arst_n(arst_n), .i_psel(psel), .i_penable(penable),
      .i_pwrite(pwrite), .i_paddr(paddr), .i_pwdata(pwdata), .i_timetag(tt), .i_evt(evt),
      .i_desc(desc), .o_pready(pready), .o_prdata(prdata), .o_pslverr(pslverr),
      .o_hardware_irq_out(hw), .o_message_irq_out(msg), .o_irq(irq));
   ieg_host_model i_ieg_host_model (.i_ref_clk(clk), .i_pready(pready), .i_prdata(prdata),
      .i_pslverr(pslverr), .o_psel(psel), .o_penable(penable), .o_pwrite(pwrite),
      .o_paddr(paddr), .o_pwdata(pwdata));

   task automatic conclude();
      $display("Comparisons %0d, mismatches %0d", cmp_count, error_cnt);
      if (error_cnt == 0 && cmp_count > 0)
         $display("RESULT: PASS");
      else
         $display("RESULT: FAIL");
      $finish;
   endtask
   task automatic chk(input logic [31:0] got, input logic [31:0] exp);
      cmp_count++;
      if (got !== exp) begin
         $display("ERROR t=%0t got=%h exp=%h", $time, got, exp);
         error_cnt++;
      end
   endtask
   // One bus transfer; a hung handshake ends the run
   task automatic rw(input bit wr, input logic [11:0] a, input logic [31:0] d);
      i_ieg_host_model.xfer(wr, a, d, rd, err);
      if (i_ieg_host_model.tmo) begin
         error_cnt++;
         conclude();
      end else begin
         @(posedge clk);
      end
   endtask

   initial begin
      void'($urandom(25));
      repeat (2) @(posedge clk);
      arst_n <= 1'b1;
      repeat (3) @(posedge clk);
      rw(0, `IEG_OFS_ENABLE, 0);
      chk(rd, 32'h7);
      rw(0, `IEG_OFS_PENDING, 0);
      chk(rd, 32'h0);
      rw(1, `IEG_OFS_ENABLE, 32'h0);
      rw(0, `IEG_OFS_ENABLE, 0);
      chk(rd, 32'h7);
      // Unmapped place: refused, no side effect on enable
      rw(1, 12'h010, 32'hffff);
      chk({31'h0, err}, 32'h1);
      rw(0, 12'h00c, 0);
      chk({31'h0, err}, 32'h1);
      chk(rd, 32'h0);
      rw(0, `IEG_OFS_ENABLE, 0);
      chk(rd, 32'h7);
      for (int i = 0; i < 60; i++) begin
         w = $urandom;
         rw(1, `IEG_OFS_ENABLE, 32'(w));
         en = (w & 'h3d08) | 7;
         rw(0, `IEG_OFS_ENABLE, 0);
         chk(rd, 32'(en));
         msk = $urandom & 'h3d0f;
         rw(1, `IEG_OFS_MASK, 32'(msk));
         tt <= 16'hffff;
         @(posedge clk);
         ev = $urandom;
         ds = $urandom;
         wrap = $urandom;
         tt <= wrap ? 16'h0000 : 16'h0001;
         evt <= ieg_pkg::ieg_evt_s'(ev);
         desc <= ieg_pkg::ieg_desc_s'(ds);
         @(posedge clk);
         evt <= '0;
         tt <= 16'h0001;
         @(posedge clk);
         #1;
         // Disabled events are dropped for good, not held for later
         set = (int'(wrap) << 3) | (ev[7] << 2) | (ev[6] << 1) | ev[5] | (ev[4] << 8)
             | (ev[3] << 10) | ((ev[2] & ds[2]) << 13) | ((ev[1] & ds[1]) << 12)
             | ((ev[0] & ds[0]) << 11);
         pend = pend | (set & en);
         chk({31'h0, hw}, 32'((pend & en & 'hf) != 0));
         chk({31'h0, msg}, 32'((pend & en & 'h3d00) != 0));
         chk({31'h0, irq}, 32'((pend & ~msk) != 0));
         @(posedge clk);
         rw(0, `IEG_OFS_PENDING, 0);
         chk(rd, 32'(pend));
         w = $urandom & 'hffff;
         rw(1, `IEG_OFS_PENDING, 32'(w));
         pend = pend & ~w;
      end
      conclude();
   end
endmodule
